//--- hw/uef_defs.svh
// offsets, field positions, reset values and timing counts of the event flags
`ifndef UEF_DEFS_SVH
`define UEF_DEFS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define UEF_OTG_STATUS_OFS 12'h000
`define UEF_OTG_ENABLE_OFS 12'h004
`define UEF_BUS_STATUS_OFS 12'h008
`define UEF_BUS_ENABLE_OFS 12'h00C
`define UEF_CTRL_OFS       12'h010
`define UEF_XFER_STAT_OFS  12'h014
`define UEF_SOF_THR_OFS    12'h018
`define UEF_LINE_OFS       12'h01C

// ****************************************************************
// field positions
// ****************************************************************
`define UEF_OTG_ID_BIT     7
`define UEF_OTG_TMR_BIT    6
`define UEF_OTG_LINE_BIT   5
`define UEF_OTG_ACT_BIT    4
`define UEF_OTG_SESV_BIT   3
`define UEF_OTG_SEND_BIT   2
`define UEF_OTG_VBUS_BIT   0
`define UEF_BUS_STALL_BIT  7
`define UEF_BUS_ATT_BIT    6
`define UEF_BUS_RES_BIT    5
`define UEF_BUS_IDLE_BIT   4
`define UEF_BUS_TOK_BIT    3
`define UEF_BUS_SOF_BIT    2
`define UEF_BUS_ERR_BIT    1
`define UEF_BUS_RST_BIT    0
`define UEF_CTRL_HOST_BIT  0
`define UEF_CTRL_FRAME_START_GENERATE_ENABLE_BIT 1
`define UEF_CTRL_LOWSP_BIT 2

// implemented bits of the otg and bus registers, and the reset value
`define UEF_OTG_MASK  8'hFD
`define UEF_BUS_MASK  8'hFF
`define UEF_RESET_VAL 8'h00

// ****************************************************************
// timing at 40 MHz
// ****************************************************************
`define UEF_CLK_NS       25
`define UEF_MS_NS        1000000
`define UEF_IDLE_NS      3000000
`define UEF_K_NS         2500
`define UEF_MS_CYC       (`UEF_MS_NS / `UEF_CLK_NS)
`define UEF_IDLE_CYC     (`UEF_IDLE_NS / `UEF_CLK_NS)
`define UEF_K_CYC        ((`UEF_K_NS + `UEF_CLK_NS - 1) / `UEF_CLK_NS)

`endif

//--- hw/uef_pkg.sv
// types shared by the usb event flag block
package uef_pkg;
  typedef struct packed {
    logic id;
    logic vbus_active;
    logic sess_valid;
    logic b_sess_end;
    logic a_vbus_valid;
  } uef_otg_in_t;

  typedef struct packed {
    logic se0;
    logic j_line_indicator;
    logic line_activity;
    logic stall_sent;
    logic token_done;
    logic sof_rx;
    logic reset_seen;
    logic detach_seen;
    logic [7:0] err_events;
    logic [7:0] xfer_stat;
  } uef_bus_in_t;

  typedef enum logic [1:0] {
    UEF_ST_IDLE = 2'b00,
    UEF_ST_ACC  = 2'b01
  } uef_apb_st_t;
endpackage : uef_pkg

//--- hw/uef_stable_timer.sv
// counts cycles a condition has held and pulses once when a limit is reached
module uef_stable_timer
  import uef_pkg::*;
#(
  parameter int LIMIT = 100
)
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // condition and result
  input  wire logic hold,
  output logic      hit
);
  localparam int W = $clog2(LIMIT + 1);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         hit;
  } uef_tmr_t;

  uef_tmr_t st;
  uef_tmr_t next_st;

  always_comb
  begin
    next_st = st;
    next_st.hit = 1'b0;
    if (!hold)
    begin
      next_st.cnt = '0;
    end
    else if (st.cnt < W'(LIMIT))
    begin
      next_st.cnt = st.cnt + W'(1);
      // one pulse exactly when the limit is first met
      next_st.hit = (st.cnt == W'(LIMIT - 1));
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st <= '0;
    else
      st <= next_st;
  end

  assign hit = st.hit;

  a_tmr_hit_exact: assert property (@(posedge pclk) disable iff (!presetn)
    hit |-> $past(hold) && st.cnt == W'(LIMIT))
    else $error("timer pulse without full hold");
endmodule : uef_stable_timer

//--- hw/uef_event_flags.sv
// sticky usb otg and bus event flags with enables, apb slave and irq
// Summary of operation
// - flags set by hardware only; write one clears, zero leaves alone
// - dual-role flags set only in host role; their enables act in both roles
// - id change sets bit 7 of the otg flags
// - every 1 ms timer expiry sets bit 6 of the otg flags
// - line state stable 1 ms and changed sets line flag
// - activity on d+, d- or vbus sets bit 4
// - vbus threshold crossings either way set bits 3, 2 and 0
// - each otg flag has a reset-zero enable at its position
// - stall handshake sent sets bus bit 7
// - host: no se0 and no activity 2.5 us sets attach
// - k-state held 2.5 us sets resume flag
// - idle held 3 ms or longer sets idle flag
// - token done sets bit 3; status readable in transfer status
// - clearing token done strobes xfer_pop, which drives no output
// - sof received as peripheral or threshold reached as host
// - error summary set only by an enabled error
// - host detach sets bit 0, not again until detach drops
// - one bus enable register for both roles, bit 0 shared
// - j means diff zero low speed, diff one full speed
// - host with sof enable issues sof every 1 ms
`include "uef_defs.svh"
module uef_event_flags
  import uef_pkg::*;
#(
  parameter int MS_CYC   = `UEF_MS_CYC,
  parameter int IDLE_CYC = `UEF_IDLE_CYC,
  parameter int K_CYC    = `UEF_K_CYC
)
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // event sources
  input  wire uef_otg_in_t otg_in,
  input  wire uef_bus_in_t bus_in,
  // results
  output logic             sof_token,
  output logic             irq
);
  typedef struct packed {
    logic [7:0]  otg_flag;
    logic [7:0]  otg_en;
    logic [7:0]  bus_flag;
    logic [7:0]  bus_en;
    logic [7:0]  err_en;
    logic [2:0]  ctrl;
    logic [7:0]  sof_thr;
    uef_otg_in_t otg_prev;
    logic [1:0]  line_stable;
    logic [1:0]  line_prev;
    logic        act_prev;
    logic        detach_lock;
    logic [15:0] frame_cnt;
    logic        sof_token;
    uef_apb_st_t apb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
  } uef_state_t;

  uef_state_t st;
  uef_state_t next_st;

  logic host;
  logic [1:0] line_now;
  logic k_state;
  logic bus_idle;
  logic line_hit;
  logic attach_hit;
  logic resume_hit;
  logic idle_hit;
  logic ms_tick;
  logic wr_acc;
  logic [7:0] otg_set;
  logic [7:0] bus_set;
  logic [7:0] wdat;

  assign host      = st.ctrl[`UEF_CTRL_HOST_BIT];
  assign line_now  = {bus_in.se0, bus_in.j_line_indicator};
  // k is the opposite differential of j when no se0
  assign k_state   = !bus_in.se0 && !bus_in.j_line_indicator;
  assign bus_idle  = !bus_in.se0 && bus_in.j_line_indicator;
  assign ms_tick   = (st.frame_cnt == 16'(MS_CYC - 1));
  assign wdat      = pwdata[7:0];

  // ****************************************************************
  // line condition timers
  // ****************************************************************
  uef_stable_timer #(.LIMIT(MS_CYC)) u_line_tmr (
    .pclk    (pclk),
    .presetn (presetn),
    .hold    (line_now == st.line_prev),
    .hit     (line_hit)
  );

  uef_stable_timer #(.LIMIT(K_CYC)) u_attach_tmr (
    .pclk    (pclk),
    .presetn (presetn),
    .hold    (!bus_in.se0 && !bus_in.line_activity),
    .hit     (attach_hit)
  );

  uef_stable_timer #(.LIMIT(K_CYC)) u_resume_tmr (
    .pclk    (pclk),
    .presetn (presetn),
    .hold    (k_state),
    .hit     (resume_hit)
  );

  uef_stable_timer #(.LIMIT(IDLE_CYC)) u_idle_tmr (
    .pclk    (pclk),
    .presetn (presetn),
    .hold    (bus_idle),
    .hit     (idle_hit)
  );

  // ****************************************************************
  // event detection
  // ****************************************************************
  always_comb
  begin
    otg_set = 8'h00;
    bus_set = 8'h00;
    if (host)
    begin
      otg_set[`UEF_OTG_ID_BIT]   = otg_in.id != st.otg_prev.id;
      otg_set[`UEF_OTG_TMR_BIT]  = ms_tick;
      // only a new stable state counts
      otg_set[`UEF_OTG_LINE_BIT] = line_hit
                                   && line_now != st.line_stable;
      otg_set[`UEF_OTG_ACT_BIT]  = bus_in.line_activity
                                   || otg_in.vbus_active;
      otg_set[`UEF_OTG_SESV_BIT] = otg_in.sess_valid
                                   != st.otg_prev.sess_valid;
      otg_set[`UEF_OTG_SEND_BIT] = otg_in.b_sess_end
                                   != st.otg_prev.b_sess_end;
      otg_set[`UEF_OTG_VBUS_BIT] = otg_in.a_vbus_valid
                                   != st.otg_prev.a_vbus_valid;
      bus_set[`UEF_BUS_ATT_BIT]  = attach_hit;
      bus_set[`UEF_BUS_RST_BIT]  = bus_in.detach_seen
                                   && !st.detach_lock;
      bus_set[`UEF_BUS_SOF_BIT]  = st.ctrl[`UEF_CTRL_FRAME_START_GENERATE_ENABLE_BIT]
        && st.frame_cnt == 16'({8'h00, st.sof_thr});
    end
    else
    begin
      bus_set[`UEF_BUS_RST_BIT]  = bus_in.reset_seen;
      bus_set[`UEF_BUS_SOF_BIT]  = bus_in.sof_rx;
    end
    bus_set[`UEF_BUS_STALL_BIT] = bus_in.stall_sent;
    bus_set[`UEF_BUS_RES_BIT]   = resume_hit;
    bus_set[`UEF_BUS_IDLE_BIT]  = idle_hit;
    bus_set[`UEF_BUS_TOK_BIT]   = bus_in.token_done;
    bus_set[`UEF_BUS_ERR_BIT]   = |(bus_in.err_events & st.err_en);
    otg_set = otg_set & `UEF_OTG_MASK;
  end

  // ****************************************************************
  // apb access and register update
  // ****************************************************************
  assign wr_acc = psel && penable && pwrite && st.apb == UEF_ST_ACC;

  always_comb
  begin
    next_st = st;
    next_st.otg_prev    = otg_in;
    next_st.act_prev    = bus_in.line_activity;
    next_st.line_prev   = line_now;
    next_st.pready      = 1'b0;
    next_st.pslverr     = 1'b0;
    next_st.sof_token   = 1'b0;
    if (line_hit)
      next_st.line_stable = line_now;
    // frame timer runs only in host role, wraps every ms
    if (host && !ms_tick)
      next_st.frame_cnt = st.frame_cnt + 16'h0001;
    else
      next_st.frame_cnt = 16'h0000;
    if (host && ms_tick && st.ctrl[`UEF_CTRL_FRAME_START_GENERATE_ENABLE_BIT])
      next_st.sof_token = 1'b1;
    // detach lock holds until the detach_seen condition goes away
    if (!bus_in.detach_seen)
      next_st.detach_lock = 1'b0;
    else if (bus_set[`UEF_BUS_RST_BIT] && host)
      next_st.detach_lock = 1'b1;

    // write one clears first, then set wins over the clear
    if (wr_acc && paddr == `UEF_OTG_STATUS_OFS)
      next_st.otg_flag = st.otg_flag & ~wdat;
    if (wr_acc && paddr == `UEF_BUS_STATUS_OFS)
      next_st.bus_flag = st.bus_flag & ~wdat;
    next_st.otg_flag = next_st.otg_flag | otg_set;
    next_st.bus_flag = next_st.bus_flag | bus_set;
    if (wr_acc)
    begin
      case (paddr)
        `UEF_OTG_ENABLE_OFS: next_st.otg_en  = wdat & `UEF_OTG_MASK;
        `UEF_BUS_ENABLE_OFS: next_st.bus_en  = wdat;
        `UEF_CTRL_OFS:       next_st.ctrl    = pwdata[2:0];
        `UEF_SOF_THR_OFS:    next_st.sof_thr = wdat;
        `UEF_XFER_STAT_OFS:  next_st.err_en  = wdat;
        default:             next_st.ctrl    = st.ctrl;
      endcase
    end

    case (st.apb)
      UEF_ST_IDLE:
      begin
        if (psel && !penable)
        begin
          next_st.apb    = UEF_ST_ACC;
          next_st.pready = 1'b1;
          next_st.prdata = 32'h0000_0000;
          case (paddr)
            `UEF_OTG_STATUS_OFS: next_st.prdata[7:0] = st.otg_flag;
            `UEF_OTG_ENABLE_OFS: next_st.prdata[7:0] = st.otg_en;
            `UEF_BUS_STATUS_OFS: next_st.prdata[7:0] = st.bus_flag;
            `UEF_BUS_ENABLE_OFS: next_st.prdata[7:0] = st.bus_en;
            `UEF_CTRL_OFS:       next_st.prdata[2:0] = st.ctrl;
            `UEF_XFER_STAT_OFS:
              next_st.prdata = {16'h0000, st.err_en, bus_in.xfer_stat};
            `UEF_SOF_THR_OFS:    next_st.prdata[7:0] = st.sof_thr;
            `UEF_LINE_OFS:       next_st.prdata[1:0] = line_now;
            default:             next_st.pslverr     = 1'b1;
          endcase
        end
      end
      UEF_ST_ACC:
      begin
        next_st.apb = UEF_ST_IDLE;
      end
      default:
      begin
        next_st.apb = UEF_ST_IDLE;
      end
    endcase

    // irq is registered from the updated flags and enables
    next_st.irq = |(next_st.otg_flag & next_st.otg_en)
                  || |(next_st.bus_flag & next_st.bus_en);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st <= '0;
    else
      st <= next_st;
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign prdata    = st.prdata;
  assign pready    = st.pready;
  assign pslverr   = st.pslverr;
  assign sof_token = st.sof_token;
  assign irq       = st.irq;

  // token done clear forms the pop strobe xfer_pop, which drives no output
  logic xfer_pop;
  assign xfer_pop = wr_acc && paddr == `UEF_BUS_STATUS_OFS
                    && wdat[`UEF_BUS_TOK_BIT];

  // ****************************************************************
  // checks
  // ****************************************************************
  a_flag_w1c: assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc && paddr == `UEF_BUS_STATUS_OFS && wdat == 8'h00
    |=> (st.bus_flag & $past(st.bus_flag)) == $past(st.bus_flag))
    else $error("zero write changed a flag");
  a_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
    bus_in.token_done |=> st.bus_flag[`UEF_BUS_TOK_BIT])
    else $error("token done flag lost");
  a_otg_guest: assert property (@(posedge pclk) disable iff (!presetn)
    !host && st.otg_flag == 8'h00 |=> st.otg_flag == 8'h00)
    else $error("otg flag set outside host role");
  a_id_change: assert property (@(posedge pclk) disable iff (!presetn)
    host && otg_in.id != $past(otg_in.id) ##1 1'b1
    |-> st.otg_flag[`UEF_OTG_ID_BIT])
    else $error("id change not flagged");
  a_ms_timer: assert property (@(posedge pclk) disable iff (!presetn)
    host && ms_tick |=> st.otg_flag[`UEF_OTG_TMR_BIT])
    else $error("timer flag missed");
  a_err_mask: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(st.bus_flag[`UEF_BUS_ERR_BIT])
    |-> $past(|(bus_in.err_events & st.err_en)))
    else $error("error summary without enabled error");
  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    irq == (|(st.otg_flag & st.otg_en) || |(st.bus_flag & st.bus_en)))
    else $error("irq disagrees with flags");
  a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && st.apb == UEF_ST_IDLE |=> pready ##1 !pready)
    else $error("apb ready not one cycle");
  a_sof_issue: assert property (@(posedge pclk) disable iff (!presetn)
    host && ms_tick && st.ctrl[`UEF_CTRL_FRAME_START_GENERATE_ENABLE_BIT] |=> sof_token)
    else $error("sof token not issued");

  // ****************************************************************
  // line and bus event checks
  // ****************************************************************
  // timer pulses are registered, so a held flag rises two edges later
  a_stall_flag: assert property (@(posedge pclk) disable iff (!presetn)
    bus_in.stall_sent |=> st.bus_flag[`UEF_BUS_STALL_BIT])
    else $error("stall flag missed");
  a_act_flag: assert property (@(posedge pclk) disable iff (!presetn)
    host && (bus_in.line_activity || otg_in.vbus_active)
    |=> st.otg_flag[`UEF_OTG_ACT_BIT])
    else $error("activity flag missed");
  a_vbus_cross: assert property (@(posedge pclk) disable iff (!presetn)
    host && otg_in.sess_valid != st.otg_prev.sess_valid
    |=> st.otg_flag[`UEF_OTG_SESV_BIT])
    else $error("session valid crossing missed");
  a_detach_set: assert property (@(posedge pclk) disable iff (!presetn)
    host && bus_in.detach_seen && !st.detach_lock
    |=> st.bus_flag[`UEF_BUS_RST_BIT])
    else $error("detach flag missed");
  a_detach_lock: assert property (@(posedge pclk) disable iff (!presetn)
    host && st.detach_lock && !st.bus_flag[`UEF_BUS_RST_BIT]
    |=> !st.bus_flag[`UEF_BUS_RST_BIT])
    else $error("detach flag set again while locked");
  a_reset_flag: assert property (@(posedge pclk) disable iff (!presetn)
    !host && bus_in.reset_seen |=> st.bus_flag[`UEF_BUS_RST_BIT])
    else $error("bus reset flag missed");
  a_resume_hold: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(st.bus_flag[`UEF_BUS_RES_BIT]) |-> $past(k_state, 2))
    else $error("resume flag without k state");
  a_idle_hold: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(st.bus_flag[`UEF_BUS_IDLE_BIT]) |-> $past(bus_idle, 2))
    else $error("idle flag without idle bus");
  a_attach_hold: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(st.bus_flag[`UEF_BUS_ATT_BIT])
    |-> $past(host) && $past(!bus_in.se0 && !bus_in.line_activity, 2))
    else $error("attach flag without quiet bus");
  a_sof_host: assert property (@(posedge pclk) disable iff (!presetn)
    host && st.ctrl[`UEF_CTRL_FRAME_START_GENERATE_ENABLE_BIT]
    && st.frame_cnt == 16'({8'h00, st.sof_thr})
    |=> st.bus_flag[`UEF_BUS_SOF_BIT])
    else $error("host sof flag missed");
endmodule : uef_event_flags

//--- tb/uef_usb_partner.sv
// usb bus side model driving id, vbus and line events into the block
module uef_usb_partner
  import uef_pkg::*;
(
  // clock
  input  wire logic  pclk,
  // bus side
  output uef_otg_in_t otg_in,
  output uef_bus_in_t bus_in
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [4:0]  otg = 5'h00;
  // full speed idle: j seen, no se0, no activity
  logic [23:0] bus = 24'h400000;

  assign otg_in = uef_otg_in_t'(otg);
  assign bus_in = uef_bus_in_t'(bus);

  // id and vbus thresholds are levels, flipped one at a time
  task automatic flip(input int i);
    @(posedge pclk);
    otg[i] <= ~otg[i];
  endtask : flip

  // handshake, token and error reports last one cycle
  task automatic pulse(input logic [23:0] m);
    @(posedge pclk);
    bus <= bus | m;
    @(posedge pclk);
    bus <= bus & ~m;
  endtask : pulse

  // detach is a level that stays up until the bus settles
  task automatic drive(input logic [23:0] m, input logic on);
    @(posedge pclk);
    bus <= on ? (bus | m) : (bus & ~m);
  endtask : drive
endmodule : uef_usb_partner

//--- tb/testbench.sv
// self-checking bench for the usb event flag block
`include "uef_defs.svh"
module testbench
  import uef_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ********************************
  // signals and bus tasks
  // ********************************
  localparam int MS = 50;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sof_token;
  logic        irq;
  uef_otg_in_t otg_in;
  uef_bus_in_t bus_in;
  logic [31:0] rd;
  logic        se;
  int          errors     = 0;
  int          n_compared = 0;
  int          cyc        = 0;

  always #12.5 pclk = ~pclk;

  uef_event_flags #(.MS_CYC(MS), .IDLE_CYC(150), .K_CYC(5)) u_uef_event_flags
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .otg_in(otg_in),
    .bus_in(bus_in), .sof_token(sof_token), .irq(irq)
  );

  uef_usb_partner u_uef_usb_partner
  (
    .pclk(pclk), .otg_in(otg_in), .bus_in(bus_in)
  );

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the bench timeout ends a wait for ready
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e)
    begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic test_done();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done

  // ********************************
  // scenarios
  // ********************************
  task automatic t_reset();
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, 12'(4 * i), 32'h0);
      chk("reset value", 32'h0, rd);
    end
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped err", 32'h1, 32'(se));
    chk("unmapped data", 32'h0, rd);
  endtask : t_reset

  // peripheral role: stall, token, frame start, bus reset
  task automatic t_bus();
    logic [23:0] m [4] = '{24'h100000, 24'h080000, 24'h040000, 24'h020000};
    int          b [4] = '{7, 3, 2, 0};
    foreach (m[i])
    begin
      u_uef_usb_partner.pulse(m[i]);
      apb(1'b0, `UEF_BUS_STATUS_OFS, 32'h0);
      chk("bus flag set", 32'h1, 32'(rd[b[i]]));
      apb(1'b1, `UEF_BUS_STATUS_OFS, 32'h0);
      apb(1'b0, `UEF_BUS_STATUS_OFS, 32'h0);
      chk("bus flag kept", 32'h1, 32'(rd[b[i]]));
      apb(1'b1, `UEF_BUS_STATUS_OFS, 32'h1 << b[i]);
      apb(1'b0, `UEF_BUS_STATUS_OFS, 32'h0);
      chk("bus flag clear", 32'h0, 32'(rd[b[i]]));
    end
  endtask : t_bus

  task automatic t_irq();
    apb(1'b1, `UEF_BUS_ENABLE_OFS, 32'h80);
    u_uef_usb_partner.pulse(24'h180000);
    repeat (2) @(posedge pclk);
    chk("irq on", 32'h1, 32'(irq));
    apb(1'b1, `UEF_BUS_ENABLE_OFS, 32'h0);
    repeat (2) @(posedge pclk);
    chk("irq masked", 32'h0, 32'(irq));
    apb(1'b1, `UEF_BUS_ENABLE_OFS, 32'h80);
    apb(1'b1, `UEF_BUS_STATUS_OFS, 32'h80);
    repeat (2) @(posedge pclk);
    chk("irq cleared", 32'h0, 32'(irq));
    apb(1'b0, `UEF_BUS_STATUS_OFS, 32'h0);
    chk("token kept", 32'h1, 32'(rd[3]));
  endtask : t_irq

  task automatic t_err();
    u_uef_usb_partner.pulse(24'h000100);
    apb(1'b0, `UEF_BUS_STATUS_OFS, 32'h0);
    chk("masked error", 32'h0, 32'(rd[1]));
    apb(1'b1, `UEF_XFER_STAT_OFS, 32'h1);
    u_uef_usb_partner.pulse(24'h000100);
    apb(1'b0, `UEF_BUS_STATUS_OFS, 32'h0);
    chk("enabled error", 32'h1, 32'(rd[1]));
  endtask : t_err

  task automatic t_role();
    u_uef_usb_partner.flip(4);
    repeat (3) @(posedge pclk);
    apb(1'b0, `UEF_OTG_STATUS_OFS, 32'h0);
    chk("otg as device", 32'h0, rd);
  endtask : t_role

  // host role: id falling then rising, each vbus threshold rising then falling
  task automatic t_otg();
    int o [4] = '{4, 2, 1, 0};
    int b [4] = '{7, 3, 2, 0};
    apb(1'b1, `UEF_CTRL_OFS, 32'h1);
    apb(1'b1, `UEF_OTG_STATUS_OFS, 32'hFD);
    for (int r = 0; r < 2; r++)
      foreach (o[i])
      begin
        u_uef_usb_partner.flip(o[i]);
        apb(1'b0, `UEF_OTG_STATUS_OFS, 32'h0);
        chk("otg flag", 32'h1, 32'(rd[b[i]]));
        chk("otg bit1", 32'h0, 32'(rd[1]));
        apb(1'b1, `UEF_OTG_STATUS_OFS, 32'h1 << b[i]);
        apb(1'b0, `UEF_OTG_STATUS_OFS, 32'h0);
        chk("otg clear", 32'h0, 32'(rd[b[i]]));
      end
  endtask : t_otg

  task automatic t_sof();
    int n;
    n = 0;
    apb(1'b1, `UEF_CTRL_OFS, 32'h3);
    apb(1'b1, `UEF_OTG_STATUS_OFS, 32'h40);
    repeat (5 * MS)
    begin
      @(posedge pclk);
      n += int'(sof_token === 1'b1);
    end
    chk("sof count", 32'd5, 32'(n));
    apb(1'b0, `UEF_OTG_STATUS_OFS, 32'h0);
    chk("ms timer", 32'h1, 32'(rd[6]));
    apb(1'b0, `UEF_BUS_STATUS_OFS, 32'h0);
    chk("host sof flag", 32'h1, 32'(rd[2]));
  endtask : t_sof

  // host role: activity flag raises irq through its enable
  task automatic t_line();
    apb(1'b1, `UEF_OTG_ENABLE_OFS, 32'h10);
    u_uef_usb_partner.pulse(24'h200000);
    repeat (2) @(posedge pclk);
    chk("activity irq", 32'h1, 32'(irq));
    apb(1'b0, `UEF_OTG_STATUS_OFS, 32'h0);
    chk("activity flag", 32'h1, 32'(rd[4]));
    apb(1'b1, `UEF_OTG_STATUS_OFS, 32'h10);
    repeat (2) @(posedge pclk);
    chk("activity cleared", 32'h0, 32'(irq));
    apb(1'b0, `UEF_OTG_ENABLE_OFS, 32'h0);
    chk("otg enable", 32'h10, rd);
  endtask : t_line

  // host role: detach flag stays locked until detach drops
  task automatic t_detach();
    u_uef_usb_partner.drive(24'h010000, 1'b1);
    apb(1'b0, `UEF_BUS_STATUS_OFS, 32'h0);
    chk("detach set", 32'h1, 32'(rd[0]));
    apb(1'b1, `UEF_BUS_STATUS_OFS, 32'h1);
    apb(1'b0, `UEF_BUS_STATUS_OFS, 32'h0);
    chk("detach locked", 32'h0, 32'(rd[0]));
    u_uef_usb_partner.drive(24'h010000, 1'b0);
    u_uef_usb_partner.drive(24'h010000, 1'b1);
    apb(1'b0, `UEF_BUS_STATUS_OFS, 32'h0);
    chk("detach again", 32'h1, 32'(rd[0]));
    u_uef_usb_partner.drive(24'h010000, 1'b0);
  endtask : t_detach

  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      errors++;
      test_done();
    end
  end

  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_bus();
    t_irq();
    t_err();
    t_role();
    t_otg();
    t_sof();
    t_line();
    t_detach();
    test_done();
  end
endmodule : testbench
